//--- core/bsd_top.v
// Boot strap option decoder: latches power-up straps, presets boot ROM
// bank 0, PLL, arbiter and reset configuration role; AXI4-Lite slave.
// Assumes straps and reset pins are asynchronous, ROM bus synchronous.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "bsd_regs.vh"

module bsd_top (
    input  wire        CLK_I,
    input  wire        RST_N_I,
    input  wire [7:0]  BOOT_STRAP_PINS_I,
    input  wire        POWER_ON_RESET_N_I,
    input  wire        HARD_RESET_N_I,
    input  wire        CFG_WORD_VALID_I,
    input  wire [31:0] CFG_WORD_I,
    input  wire        ROM_REQ_I,
    input  wire [31:0] ROM_ADDR_I,
    input  wire        ROM_READY_IN_I,
    input  wire [7:0]  ROM_PIN_DATA_I,
    input  wire [63:0] SDRAM_DATA_BUS_I,
    output wire        BOOT_CHIP_SELECT0_O,
    output wire        ROM_ACK_O,
    output wire        ROM_MISS_O,
    output wire [63:0] ROM_DATA_O,
    output reg         PLL_ON_O,
    output reg  [3:0]  ARB_CH_EN_O,
    output reg         PARITY_DIS_O,
    output reg         CFG_ROLE_SLAVE_O,
    output reg  [2:0]  CFG_ADDR_LINE_O,
    output reg         CONFIG_DONE_O,
    input  wire [31:0] AXI_AWADDR_I,
    input  wire        AXI_AWVALID_I,
    output reg         AXI_AWREADY_O,
    input  wire [31:0] AXI_WDATA_I,
    input  wire [3:0]  AXI_WSTRB_I,
    input  wire        AXI_WVALID_I,
    output reg         AXI_WREADY_O,
    output reg  [1:0]  AXI_BRESP_O,
    output reg         AXI_BVALID_O,
    input  wire        AXI_BREADY_I,
    input  wire [31:0] AXI_ARADDR_I,
    input  wire        AXI_ARVALID_I,
    output reg         AXI_ARREADY_O,
    output reg  [31:0] AXI_RDATA_O,
    output reg  [1:0]  AXI_RRESP_O,
    output reg         AXI_RVALID_O,
    input  wire        AXI_RREADY_I
);
    // Register index from a byte address, shared by both bus paths
    function [2:0] reg_sel;
        input [31:0] a;
        begin
            case (a[7:0])
                `BSD_OFF_GEN:    reg_sel = `BSD_SEL_GEN;
                `BSD_OFF_ARB:    reg_sel = `BSD_SEL_ARB;
                `BSD_OFF_B0CTRL: reg_sel = `BSD_SEL_B0CTRL;
                `BSD_OFF_B0ADDR: reg_sel = `BSD_SEL_B0ADDR;
                `BSD_OFF_STRAP:  reg_sel = `BSD_SEL_STRAP;
                default:         reg_sel = `BSD_SEL_NONE;
            endcase
            if (a[31:8] != 24'h0) begin
                reg_sel = `BSD_SEL_NONE;
            end
        end
    endfunction

    wire [7:0]  strap_sync;
    wire        por_n_sync;
    wire        hrst_n_sync;
    wire        ready_sync;

    reg  [7:0]  strap_reg;
    reg  [7:0]  strap_last_reg;
    reg  [3:0]  stable_cnt_reg;
    reg         stable_reg;
    reg         por_prev_reg;
    reg         hrst_prev_reg;
    reg         cfg_ovr_reg;

    reg         port_reg;
    reg         re_reg;
    reg  [1:0]  width_reg;
    reg         enable_reg;
    reg  [1:0]  mux_reg;
    reg  [23:0] base_reg;

    reg         aw_hold_reg;
    reg  [31:0] awaddr_reg;
    reg         w_hold_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;

    wire        dps;
    wire [1:0]  wid;
    wire        rom_off;
    wire [1:0]  arb_code;
    reg  [3:0]  arb_en;
    wire        hrst_rise;
    wire        do_write;
    wire [2:0]  wsel;
    wire        wfull;
    reg  [31:0] rd_word;
    reg         rd_hit;
    integer     i;

    bsd_sync3 #(
        .W (11)
    ) u_sync (
        .clk_i     (CLK_I),
        .rst_n_i   (RST_N_I),
        .d_i       ({ROM_READY_IN_I, HARD_RESET_N_I,
                     POWER_ON_RESET_N_I, BOOT_STRAP_PINS_I}),
        .rst_val_i (11'h000),
        .q_o       ({ready_sync, hrst_n_sync, por_n_sync, strap_sync})
    );

    bsd_rom_gate u_rom (
        .clk_i      (CLK_I),
        .rst_n_i    (RST_N_I),
        .req_i      (ROM_REQ_I),
        .addr_i     (ROM_ADDR_I),
        .enable_i   (enable_reg),
        .base_i     (base_reg),
        .port_i     (port_reg),
        .width_i    (width_reg),
        .re_i       (re_reg),
        .ready_i    (ready_sync),
        .pin_data_i (ROM_PIN_DATA_I),
        .sd_data_i  (SDRAM_DATA_BUS_I),
        .cs_o       (BOOT_CHIP_SELECT0_O),
        .ack_o      (ROM_ACK_O),
        .miss_o     (ROM_MISS_O),
        .data_o     (ROM_DATA_O)
    );

    // Decode of the latched strap byte
    assign dps      = strap_reg[`BSD_S_PORT];
    assign wid      = {strap_reg[`BSD_S_WID_HI], strap_reg[`BSD_S_WID_LO]};
    assign rom_off  = !dps && (wid == `BSD_WID_16);
    assign arb_code = {strap_reg[`BSD_S_ARB_HI], strap_reg[`BSD_S_ARB_LO]};
    assign hrst_rise = hrst_n_sync && !hrst_prev_reg;

    always @* begin
        case (arb_code)
            2'b00:   arb_en = `BSD_ARB_NONE;
            2'b01:   arb_en = `BSD_ARB_01;
            2'b10:   arb_en = `BSD_ARB_012;
            default: arb_en = `BSD_ARB_0123;
        endcase
    end

    // Strap capture while power-on reset is low, word overwrite after
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            strap_reg      <= 8'h00;
            strap_last_reg <= 8'h00;
            stable_cnt_reg <= `BSD_CNT_ZERO;
            stable_reg     <= 1'b0;
            por_prev_reg   <= 1'b0;
            hrst_prev_reg  <= 1'b0;
            cfg_ovr_reg    <= 1'b0;
        end else begin
            por_prev_reg   <= por_n_sync;
            hrst_prev_reg  <= hrst_n_sync;
            strap_last_reg <= strap_sync;
            if (!por_n_sync) begin
                strap_reg   <= strap_sync;
                cfg_ovr_reg <= 1'b0;
                // Hold check only flags a short hold, it never blocks
                if (strap_sync != strap_last_reg) begin
                    stable_cnt_reg <= `BSD_CNT_ONE;
                end else if (stable_cnt_reg != `BSD_STABLE_CLKS) begin
                    stable_cnt_reg <= stable_cnt_reg + `BSD_CNT_ONE;
                end
            end else if (!hrst_n_sync && CFG_WORD_VALID_I) begin
                // Word bit 7 lands on strap 0, bit 0 on strap 7
                for (i = 0; i < 8; i = i + 1) begin
                    strap_reg[i] <= CFG_WORD_I[7-i];
                end
                cfg_ovr_reg <= 1'b1;
            end
            if (!por_n_sync) begin
                stable_reg <= 1'b0;
            end else if (!por_prev_reg) begin
                stable_reg <= (stable_cnt_reg == `BSD_STABLE_CLKS);
            end
        end
    end

    // Bus write path
    assign do_write = aw_hold_reg && w_hold_reg && !AXI_BVALID_O;
    assign wsel     = reg_sel(awaddr_reg);
    assign wfull    = (wstrb_reg == `BSD_STRB_ALL);

    // Option fields load at hard reset release; that load beats a write
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            port_reg         <= 1'b0;
            re_reg           <= 1'b0;
            width_reg        <= `BSD_WID_8;
            enable_reg       <= 1'b0;
            mux_reg          <= `BSD_MUX_PINS;
            base_reg         <= `BSD_B0_BASE;
            PLL_ON_O         <= 1'b0;
            ARB_CH_EN_O      <= `BSD_ARB_NONE;
            PARITY_DIS_O     <= 1'b0;
            CFG_ROLE_SLAVE_O <= 1'b0;
            CFG_ADDR_LINE_O  <= 3'h0;
            CONFIG_DONE_O    <= 1'b0;
        end else if (!hrst_n_sync) begin
            CONFIG_DONE_O <= 1'b0;
        end else if (hrst_rise) begin
            port_reg         <= dps;
            mux_reg          <= dps ? `BSD_MUX_SDRAM : `BSD_MUX_PINS;
            re_reg           <= strap_reg[`BSD_S_RE];
            width_reg        <= wid;
            enable_reg       <= !rom_off;
            base_reg         <= `BSD_B0_BASE;
            PLL_ON_O         <= !strap_reg[`BSD_S_PLL];
            ARB_CH_EN_O      <= arb_en;
            PARITY_DIS_O     <= arb_code[1];
            CFG_ROLE_SLAVE_O <= strap_reg[`BSD_S_ROLE];
            CFG_ADDR_LINE_O  <= {strap_reg[`BSD_S_WID_LO],
                                 strap_reg[`BSD_S_WID_HI], dps};
            CONFIG_DONE_O    <= 1'b1;
        end else if (do_write && wfull) begin
            if (wsel == `BSD_SEL_B0CTRL) begin
                port_reg  <= wdata_reg[`BSD_F_PORT];
                mux_reg   <= wdata_reg[`BSD_F_PORT] ? `BSD_MUX_SDRAM
                                                    : `BSD_MUX_PINS;
                re_reg    <= wdata_reg[`BSD_F_RE];
                width_reg <= wdata_reg[`BSD_F_WID];
            end else if (wsel == `BSD_SEL_B0ADDR) begin
                enable_reg <= wdata_reg[`BSD_F_EN];
                mux_reg    <= wdata_reg[`BSD_F_MUX];
                base_reg   <= wdata_reg[`BSD_F_BASE];
            end
        end
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            aw_hold_reg   <= 1'b0;
            awaddr_reg    <= 32'h0;
            w_hold_reg    <= 1'b0;
            wdata_reg     <= 32'h0;
            wstrb_reg     <= 4'h0;
            AXI_AWREADY_O <= 1'b1;
            AXI_WREADY_O  <= 1'b1;
            AXI_BVALID_O  <= 1'b0;
            AXI_BRESP_O   <= `BSD_RESP_OKAY;
        end else begin
            if (AXI_AWVALID_I && AXI_AWREADY_O) begin
                aw_hold_reg   <= 1'b1;
                awaddr_reg    <= AXI_AWADDR_I;
                AXI_AWREADY_O <= 1'b0;
            end
            if (AXI_WVALID_I && AXI_WREADY_O) begin
                w_hold_reg   <= 1'b1;
                wdata_reg    <= AXI_WDATA_I;
                wstrb_reg    <= AXI_WSTRB_I;
                AXI_WREADY_O <= 1'b0;
            end
            if (do_write) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                AXI_BVALID_O <= 1'b1;
                AXI_BRESP_O  <= (wsel == `BSD_SEL_NONE) ? `BSD_RESP_DECERR
                                                        : `BSD_RESP_OKAY;
            end
            if (AXI_BVALID_O && AXI_BREADY_I) begin
                AXI_BVALID_O  <= 1'b0;
                AXI_AWREADY_O <= 1'b1;
                AXI_WREADY_O  <= 1'b1;
            end
        end
    end

    // Read mux; general and arbiter fields are read-only status, bank 0 fields are writable
    always @* begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (reg_sel(AXI_ARADDR_I))
            `BSD_SEL_GEN: begin
                rd_word[0]   = PLL_ON_O;
                rd_word[1]   = CFG_ROLE_SLAVE_O;
                rd_word[4:2] = CFG_ADDR_LINE_O;
                rd_word[5]   = CONFIG_DONE_O;
            end
            `BSD_SEL_ARB: begin
                rd_word[3:0] = ARB_CH_EN_O;
                rd_word[4]   = PARITY_DIS_O;
            end
            `BSD_SEL_B0CTRL: begin
                rd_word[`BSD_F_PORT] = port_reg;
                rd_word[`BSD_F_RE]   = re_reg;
                rd_word[`BSD_F_WID]  = width_reg;
            end
            `BSD_SEL_B0ADDR: begin
                rd_word[`BSD_F_EN]   = enable_reg;
                rd_word[`BSD_F_MUX]  = mux_reg;
                rd_word[`BSD_F_BASE] = base_reg;
            end
            `BSD_SEL_STRAP: begin
                rd_word[7:0] = strap_reg;
                rd_word[8]   = stable_reg;
                rd_word[9]   = cfg_ovr_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O  <= 1'b0;
            AXI_RDATA_O   <= 32'h0;
            AXI_RRESP_O   <= `BSD_RESP_OKAY;
        end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O  <= 1'b1;
            AXI_RDATA_O   <= rd_word;
            AXI_RRESP_O   <= rd_hit ? `BSD_RESP_OKAY : `BSD_RESP_DECERR;
        end else if (AXI_RVALID_O && AXI_RREADY_I) begin
            AXI_RVALID_O  <= 1'b0;
            AXI_ARREADY_O <= 1'b1;
        end
    end
endmodule // bsd_top

//--- core/bsd_regs.vh
// Constants of the boot strap option decoder: bus offsets, fields,
// reset values and counts. Included by the design files, defines only.
`ifndef BSD_REGS_VH
`define BSD_REGS_VH

// Register byte offsets on the AXI4-Lite bus
`define BSD_OFF_GEN      8'h00
`define BSD_OFF_ARB      8'h04
`define BSD_OFF_B0CTRL   8'h08
`define BSD_OFF_B0ADDR   8'h0c
`define BSD_OFF_STRAP    8'h10

// Register select codes
`define BSD_SEL_GEN      3'h0
`define BSD_SEL_ARB      3'h1
`define BSD_SEL_B0CTRL   3'h2
`define BSD_SEL_B0ADDR   3'h3
`define BSD_SEL_STRAP    3'h4
`define BSD_SEL_NONE     3'h7

// Bus responses
`define BSD_RESP_OKAY    2'b00
`define BSD_RESP_DECERR  2'b11
`define BSD_STRB_ALL     4'hf

// Strap bit positions, bit n is strap pin n
`define BSD_S_PLL        0
`define BSD_S_RE         1
`define BSD_S_ARB_HI     2
`define BSD_S_ARB_LO     3
`define BSD_S_ROLE       4
`define BSD_S_PORT       5
`define BSD_S_WID_HI     6
`define BSD_S_WID_LO     7

// Address multiplexing presets and width codes
`define BSD_MUX_PINS     2'b11
`define BSD_MUX_SDRAM    2'b01
`define BSD_WID_8        2'b00
`define BSD_WID_16       2'b01
`define BSD_WID_32       2'b10
`define BSD_WID_64       2'b11

// Arbiter channel enable sets
`define BSD_ARB_NONE     4'h0
`define BSD_ARB_01       4'h3
`define BSD_ARB_012      4'h7
`define BSD_ARB_0123     4'hf

// Bank 0 base address preset
`define BSD_B0_BASE      24'hfff001

// Field positions in the bank 0 registers
`define BSD_F_PORT       0
`define BSD_F_RE         1
`define BSD_F_WID        3:2
`define BSD_F_EN         0
`define BSD_F_MUX        2:1
`define BSD_F_BASE       31:8

// Strap hold time before power-on release, in bus clocks
`define BSD_STABLE_CLKS  4'ha
`define BSD_CNT_ZERO     4'h0
`define BSD_CNT_ONE      4'h1

`endif

//--- core/bsd_sync3.v
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from pins outside the CLK_I domain.
`timescale 1ns/100ps
`include "bsd_regs.vh"

module bsd_sync3 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] d_i,
    input  wire [W-1:0] rst_val_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] ff1_reg;
    reg [W-1:0] ff2_reg;
    reg [W-1:0] ff3_reg;
    genvar g;

    always @(posedge clk_i) begin
        ff1_reg <= d_i;
        ff2_reg <= ff1_reg;
        ff3_reg <= ff2_reg;
    end

    // Each bit moves only when stages two and three agree
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    q_o[g] <= rst_val_i[g];
                end else if (ff2_reg[g] == ff3_reg[g]) begin
                    q_o[g] <= ff3_reg[g];
                end
            end
        end
    endgenerate
endmodule // bsd_sync3

//--- core/bsd_rom_gate.v
// Boot ROM bank 0 access gate: decode, chip select, ready wait, lanes.
// Assumes requests and ROM data are synchronous to clk_i.
`timescale 1ns/100ps
`include "bsd_regs.vh"

module bsd_rom_gate (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        req_i,
    input  wire [31:0] addr_i,
    input  wire        enable_i,
    input  wire [23:0] base_i,
    input  wire        port_i,
    input  wire [1:0]  width_i,
    input  wire        re_i,
    input  wire        ready_i,
    input  wire [7:0]  pin_data_i,
    input  wire [63:0] sd_data_i,
    output reg         cs_o,
    output reg         ack_o,
    output reg         miss_o,
    output reg  [63:0] data_o
);
    wire        hit;
    reg  [63:0] lane_data;

    // Disabled bank answers nothing at or above its base
    assign hit = enable_i && (addr_i[31:8] >= base_i);

    always @* begin
        lane_data = 64'h0;
        if (!port_i) begin
            lane_data = {56'h0, pin_data_i};
        end else begin
            case (width_i)
                `BSD_WID_8:  lane_data = {56'h0, sd_data_i[7:0]};
                `BSD_WID_16: lane_data = {48'h0, sd_data_i[15:0]};
                `BSD_WID_32: lane_data = {32'h0, sd_data_i[31:0]};
                default:     lane_data = sd_data_i;
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cs_o   <= 1'b0;
            ack_o  <= 1'b0;
            miss_o <= 1'b0;
            data_o <= 64'h0;
        end else begin
            ack_o  <= 1'b0;
            miss_o <= 1'b0;
            if (cs_o) begin
                // Without throttling the ready pin is ignored
                if (!re_i || ready_i) begin
                    cs_o   <= 1'b0;
                    ack_o  <= 1'b1;
                    data_o <= lane_data;
                end
            end else if (req_i && !ack_o && !miss_o) begin
                if (hit) begin
                    cs_o <= 1'b1;
                end else begin
                    miss_o <= 1'b1;
                end
            end
        end
    end
endmodule // bsd_rom_gate

//--- bench/bsd_monitor.sv
// Checker on the bsd_top ports: ROM gate, option fields, AXI timing.
// Assumes it is bound onto bsd_top; one clock, sync active low reset.
`timescale 1ns/100ps
module bsd_monitor (
    input wire        CLK_I,
    input wire        RST_N_I,
    input wire        HARD_RESET_N_I,
    input wire        ROM_REQ_I,
    input wire [31:0] ROM_ADDR_I,
    input wire        BOOT_CHIP_SELECT0_O,
    input wire        ROM_ACK_O,
    input wire        ROM_MISS_O,
    input wire [3:0]  ARB_CH_EN_O,
    input wire        PARITY_DIS_O,
    input wire        CONFIG_DONE_O,
    input wire        AXI_AWVALID_I,
    input wire        AXI_AWREADY_O,
    input wire        AXI_WVALID_I,
    input wire        AXI_WREADY_O,
    input wire        AXI_BVALID_O,
    input wire [31:0] AXI_ARADDR_I,
    input wire        AXI_ARVALID_I,
    input wire        AXI_ARREADY_O,
    input wire        AXI_RVALID_O,
    input wire        AXI_RREADY_I,
    input wire [31:0] AXI_RDATA_O,
    input wire [1:0]  AXI_RRESP_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Parity drops exactly with the 0-2 and 0-3 channel sets
    parity_arb_a: assert property (
        PARITY_DIS_O == ARB_CH_EN_O[2]) else $error("parity flag wrong");
    done_low_a: assert property (
        !HARD_RESET_N_I [*6] |-> !CONFIG_DONE_O) else $error("done early");
    low_miss_a: assert property (
        ROM_REQ_I && !BOOT_CHIP_SELECT0_O && !ROM_ACK_O && !ROM_MISS_O
        && ROM_ADDR_I[31:8] < 24'hfff001 |=> ROM_MISS_O)
        else $error("no miss below base");
    cs_ack_a: assert property (
        $fell(BOOT_CHIP_SELECT0_O) |-> ROM_ACK_O) else $error("cs dropped");
    ack_pulse_a: assert property (
        ROM_ACK_O |=> !ROM_ACK_O) else $error("ack too long");
    bresp_time_a: assert property (
        AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O
        |=> !AXI_BVALID_O ##1 AXI_BVALID_O) else $error("bvalid late");
    rdata_hold_a: assert property (
        AXI_RVALID_O && !AXI_RREADY_I |=> AXI_RVALID_O
        && $stable(AXI_RDATA_O)) else $error("rdata moved");
    decerr_rd_a: assert property (
        AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I[31:8] != 24'h0
        |=> AXI_RVALID_O && AXI_RRESP_O == 2'b11 && AXI_RDATA_O == 32'h0)
        else $error("unmapped read");
endmodule // bsd_monitor
bind bsd_top bsd_monitor mon_u (.*);

//--- bench/bsd_strap_drv.sv
// Far side of bsd_top: strap drivers, reset pins, config word, boot ROM.
// Assumes the bench calls power_up and sets the ROM contents directly.
`timescale 1ns/100ps
module bsd_strap_drv (
    input  wire        clk_i,
    input  wire        cs_i,
    output reg  [7:0]  pins_o,
    output reg         por_n_o,
    output reg         hrst_n_o,
    output reg         ready_o,
    output wire [7:0]  pin_o,
    output wire [63:0] sd_o,
    output reg         cv_o,
    output reg  [31:0] cw_o
);
    reg [7:0]  rom_byte;
    reg [63:0] sd_word;
    reg [3:0]  lat = 4'h6;
    reg [3:0]  wait_cnt = 4'h0;
    reg        flip = 1'b0;
    initial begin
        {pins_o, por_n_o, hrst_n_o, ready_o, cv_o, cw_o} = 44'h0;
    end
    // Unselected ROM lines toggle, so a stale capture cannot match
    assign pin_o = cs_i ? rom_byte : {8{flip}};
    assign sd_o = cs_i ? sd_word : {64{flip}};
    always @(posedge clk_i) begin
        flip <= ~flip;
        wait_cnt <= cs_i ? wait_cnt + 4'h1 : 4'h0;
        ready_o <= cs_i && wait_cnt >= lat;
    end
    task power_up(input [7:0] s, input [31:0] w, input uw);
        begin
            @(posedge clk_i);
            por_n_o <= 1'b0;
            hrst_n_o <= 1'b0;
            pins_o <= s;
            repeat (16) @(posedge clk_i);
            por_n_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            pins_o <= ~s;
            repeat (3) @(posedge clk_i);
            cv_o <= uw;
            cw_o <= w;
            @(posedge clk_i);
            cv_o <= 1'b0;
            cw_o <= ~w;
            repeat (2) @(posedge clk_i);
            hrst_n_o <= 1'b1;
        end
    endtask
endmodule // bsd_strap_drv

//--- bench/bsd_top_tb.sv
// Bench of bsd_top: strap cases, option registers, boot ROM accesses.
// Assumes bsd_strap_drv as partner and bsd_monitor bound to the top.
`timescale 1ns/100ps
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin \
 failures++; $display("[FAIL] %s exp %h got %h", n, e, v); end end
module bsd_top_tb;
    reg CLK_I = 0, RST_N_I = 0, ROM_REQ_I = 0, AXI_AWVALID_I = 0;
    reg AXI_WVALID_I = 0, AXI_BREADY_I = 0, AXI_ARVALID_I = 0;
    reg AXI_RREADY_I = 0;
    reg [31:0] ROM_ADDR_I = 0, AXI_AWADDR_I = 0, AXI_WDATA_I = 0;
    reg [31:0] AXI_ARADDR_I = 0;
    reg [3:0] AXI_WSTRB_I = 4'hf;
    wire [7:0] BOOT_STRAP_PINS_I, ROM_PIN_DATA_I;
    wire [63:0] SDRAM_DATA_BUS_I, ROM_DATA_O;
    wire [31:0] CFG_WORD_I, AXI_RDATA_O;
    wire POWER_ON_RESET_N_I, HARD_RESET_N_I, ROM_READY_IN_I;
    wire CFG_WORD_VALID_I, BOOT_CHIP_SELECT0_O, ROM_ACK_O, ROM_MISS_O;
    wire PLL_ON_O, PARITY_DIS_O, CFG_ROLE_SLAVE_O, CONFIG_DONE_O;
    wire AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O;
    wire AXI_RVALID_O;
    wire [1:0] AXI_BRESP_O, AXI_RRESP_O;
    wire [3:0] ARB_CH_EN_O;
    wire [2:0] CFG_ADDR_LINE_O;
    integer failures = 0, checks_done = 0, cyc = 0, n, i;
    reg [33:0] rq[$];
    reg [64:0] mq[$];
    reg [33:0] e34;
    reg [64:0] e65;
    reg [8:0] tbl[0:6];
    reg [31:0] g, a;
    reg [7:0] s, rv;
    reg [63:0] m, d64;
    reg [2:0] k;
    reg u, slow = 0;
    bsd_top dut_u (.*);
    bsd_strap_drv drv_u (.clk_i(CLK_I), .cs_i(BOOT_CHIP_SELECT0_O),
        .pins_o(BOOT_STRAP_PINS_I), .por_n_o(POWER_ON_RESET_N_I),
        .hrst_n_o(HARD_RESET_N_I), .ready_o(ROM_READY_IN_I),
        .pin_o(ROM_PIN_DATA_I), .sd_o(SDRAM_DATA_BUS_I),
        .cv_o(CFG_WORD_VALID_I), .cw_o(CFG_WORD_I));
    always #2.5 CLK_I = ~CLK_I;
    function [31:0] ev(input [2:0] r, input [7:0] s, input uw);
        reg [1:0] w, c;
        begin
            w = {s[6], s[7]};
            c = {s[2], s[3]};
            case (r)
                0: ev = {27'h1, s[7:4], !s[0]};
                1: ev = {27'h0, c[1], c[1] ? {c[0], 3'h7} : {2'h0, {2{c[0]}}}};
                2: ev = {28'h0, w, s[1], s[5]};
                3: ev = {29'h1ffe0020, s[5] ? 2'b01 : 2'b11, w != 1 || s[5]};
                default: ev = {22'h0, uw, 1'b1, s};
            endcase
        end
    endfunction
    task wr(input [31:0] ad, input [31:0] d, input [1:0] r);
        begin
            rq.push_back({r, 32'h0});
            @(posedge CLK_I);
            {AXI_AWADDR_I, AXI_WDATA_I} <= {ad, d};
            // Response ready from the start, dropped once bvalid is seen
            {AXI_AWVALID_I, AXI_WVALID_I, AXI_BREADY_I} <= 3'b111;
            do begin
                @(posedge CLK_I);
                if (AXI_AWREADY_O) AXI_AWVALID_I <= 0;
                if (AXI_WREADY_O) AXI_WVALID_I <= 0;
            end while (!AXI_BVALID_O);
            AXI_BREADY_I <= 0;
        end
    endtask
    task rd(input [31:0] ad, input [33:0] ex);
        begin
            rq.push_back(ex);
            @(posedge CLK_I);
            AXI_ARADDR_I <= ad;
            AXI_ARVALID_I <= 1;
            // Slow reads raise rready only after rvalid, to stall the data
            AXI_RREADY_I <= !slow;
            do begin
                @(posedge CLK_I);
                if (AXI_ARREADY_O) AXI_ARVALID_I <= 0;
                if (AXI_RVALID_O && !AXI_RREADY_I) AXI_RREADY_I <= 1;
            end while (!(AXI_RVALID_O && AXI_RREADY_I));
            AXI_RREADY_I <= 0;
        end
    endtask
    task rom(input [31:0] ad, input [64:0] ex);
        begin
            mq.push_back(ex);
            @(posedge CLK_I);
            ROM_ADDR_I <= ad;
            ROM_REQ_I <= 1;
            n = 0;
            do begin
                @(posedge CLK_I);
                n++;
            end while (!(ROM_ACK_O || ROM_MISS_O));
            ROM_REQ_I <= 0;
        end
    endtask
    task conclude;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Result watcher: oldest note against each answer that appears
    always @(posedge CLK_I) begin
        cyc++;
        if (AXI_RVALID_O && AXI_RREADY_I) begin
            e34 = rq.pop_front();
            `CHK("axi_r", e34, {AXI_RRESP_O, AXI_RDATA_O})
        end
        if (AXI_BVALID_O && AXI_BREADY_I) begin
            e34 = rq.pop_front();
            `CHK("axi_b", e34[33:32], AXI_BRESP_O)
        end
        if (ROM_ACK_O || ROM_MISS_O) begin
            e65 = mq.pop_front();
            d64 = ROM_MISS_O ? 64'h0 : ROM_DATA_O;
            `CHK("rom", e65, {ROM_MISS_O, d64})
        end
        if (cyc == 20000) begin
            failures++;
            conclude;
        end
    end
    initial begin
        rv = $urandom(32'h8273);
        tbl[0] = 9'h000;
        tbl[1] = 9'h080;
        tbl[2] = 9'h07a;
        tbl[3] = 9'h0e5;
        tbl[4] = 9'h0af;
        tbl[5] = 9'h13c;
        tbl[6] = {1'b0, 8'($urandom)};
        drv_u.rom_byte = 8'($urandom);
        drv_u.sd_word = {$urandom, $urandom};
        repeat (5) @(posedge CLK_I);
        RST_N_I <= 1;
        for (i = 0; i < 7; i++) begin
            {u, s} = tbl[i];
            for (n = 0; n < 8; n++) rv[n] = s[7-n];
            drv_u.power_up(u ? ~s : s, {24'h0, rv}, u);
            for (n = 0; n < 30 && CONFIG_DONE_O !== 1; n++) @(posedge CLK_I);
            g = ev(0, s, u);
            `CHK("done", 1'b1, CONFIG_DONE_O)
            `CHK("pll", g[0], PLL_ON_O)
            `CHK("role", g[4:1], {CFG_ADDR_LINE_O, CFG_ROLE_SLAVE_O})
            g = ev(1, s, u);
            `CHK("arb", g[4:0], {PARITY_DIS_O, ARB_CH_EN_O})
            slow = i[0];
            for (k = 0; k < 5; k++)
                rd({27'h0, k, 2'b00}, {2'b00, ev(k, s, u)});
            g = ev(2, s, u);
            a = ev(3, s, u);
            m = g[2] ? 64'hffff : 64'hff;
            if (g[3]) m = g[2] ? ~64'h0 : 64'hffffffff;
            rom(32'hfff00100, a[0] ? {1'b0, s[5] ? drv_u.sd_word & m
                : {56'h0, drv_u.rom_byte}} : {1'b1, 64'h0});
            if (a[0]) `CHK("rom_wait", s[1] ? n > 9 : n == 3, 1'b1)
            rom(32'hfff00000, {1'b1, 64'h0});
        end
        wr(32'h08, {28'h0, 3'b101, ~s[5]}, 2'b00);
        rd(32'h08, {30'h0, 3'b101, ~s[5]});
        rd(32'h0c, {2'b00, a[31:3], s[5] ? 2'b11 : 2'b01, a[0]});
        wr(32'h00, 32'hffffffff, 2'b00);
        rd(32'h00, {2'b00, ev(0, s, 1'b0)});
        wr(32'h100, 32'h0, 2'b11);
        rd(32'h100, {2'b11, 32'h0});
        conclude;
    end
endmodule // bsd_top_tb
